// ==== hdl/asp_params.svh ====
// constants for the asynchronous serial port: apb offsets, field positions, counts
// assumes inclusion by hdl/asp_serial_port.sv; hdl/asp_pkg.sv does not include it
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
// ==========================================
// register offsets (byte addresses)
`define ASP_OFS_CTRL 12'h000
`define ASP_OFS_BUF 12'h004
`define ASP_OFS_CFG 12'h008
// ==========================================
// control register fields
`define ASP_CTRL_RST 8'h00
`define ASP_BIT_RB8 2
`define ASP_BIT_TB8 3
// ==========================================
// configuration register fields
`define ASP_CFG_DBL 7
`define ASP_CFG_RCLK 5
`define ASP_CFG_TCLK 4
// double-rate bit position inside the host's power / extended control registers
`define ASP_DBL_SRC_BIT 7
// ==========================================
// timing counts
`define ASP_M2_LIM_NORM 2'h3
`define ASP_M2_LIM_DBL 2'h1
`define ASP_SMP_A 4'h7
`define ASP_SMP_B 4'h8
`define ASP_SMP_C 4'h9
`define ASP_WRAP 4'hf
`define ASP_LAST_IDX 4'h8
`define ASP_TX_BITS_M1 4'ha
`define ASP_TX_BITS_M23 4'hb
`endif

// ==== hdl/asp_pkg.sv ====
// types for the asynchronous serial port
// assumes asp_params.svh beside it
`default_nettype none
package asp_pkg;
  // ==========================================
  // control register layout, msb first
  typedef struct packed {
    logic [1:0] mode;
    logic address_filter_mode;
    logic ren;
    logic transmit_ninth_bit;
    logic received_ninth_bit;
    logic transmit_done_flag;
    logic receive_full_flag;
  } asp_ctrl_t;
  // ==========================================
  // baud source configuration
  typedef struct packed {
    logic double_rate_bit;
    logic rclk_t2;
    logic tclk_t2;
  } asp_cfg_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} asp_rx_st_t;
endpackage : asp_pkg
`default_nettype wire

// ==== hdl/asp_serial_port.sv ====
// asynchronous serial port, modes 1 to 3, apb register slave
// assumes timer overflow pulses on mclk and an unsynchronised receive pin
`include "asp_params.svh"
`default_nettype none
module asp_serial_port #(
  parameter int PORT_ID = 0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // baud sources
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  // serial pins
  input wire logic rxd,
  output logic txd
);
  // ==========================================
  // elaboration check
  if (PORT_ID < 0 || PORT_ID > 1) begin : g_bad
    $error("PORT_ID must be 0 or 1");
  end

  asp_pkg::asp_ctrl_t ctrl_r, ctrl_nxt;
  asp_pkg::asp_cfg_t cfg_r, cfg_nxt;
  asp_pkg::asp_rx_st_t rst_r, rst_nxt;
  logic [7:0] rbuf_r, rbuf_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic rx_m_r, rx_s_r, rx_d_r;
  logic [1:0] m2cnt_r, m2cnt_nxt;
  logic t1_half_r, t1_half_nxt;
  logic [3:0] rcnt_r, rcnt_nxt, ridx_r, ridx_nxt;
  logic [1:0] smp_r, smp_nxt;
  logic [8:0] rsh_r, rsh_nxt;
  logic [3:0] tcnt_r, tcnt_nxt, trem_r, trem_nxt;
  logic [10:0] tsh_r, tsh_nxt;
  logic txd_r, txd_nxt;
  // combinational helpers
  logic wr_acc, rd_setup, unmapped, m2_lim_hit, m2_tick, t1_tick, rx_tick, tx_tick;
  logic bitv, fire, lastbit, load_ok, set_ri, set_ti, tx_wrap;
  logic [8:0] rvec;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  // ==========================================
  // apb decode: zero wait states, error on unmapped address
  always_comb begin
    unmapped = (paddr != `ASP_OFS_CTRL) && (paddr != `ASP_OFS_BUF) && (paddr != `ASP_OFS_CFG);
    wr_acc = psel && penable && pwrite && !unmapped;
    rd_setup = psel && !penable && !pwrite;
    pready = 1'b1;
    pslverr = psel && penable && unmapped;
  end

  // ==========================================
  // next-state logic
  always_comb begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    rst_nxt = rst_r;
    rbuf_nxt = rbuf_r;
    prdata_nxt = prdata_r;
    rcnt_nxt = rcnt_r;
    ridx_nxt = ridx_r;
    smp_nxt = smp_r;
    rsh_nxt = rsh_r;
    tcnt_nxt = tcnt_r;
    trem_nxt = trem_r;
    tsh_nxt = tsh_r;
    txd_nxt = txd_r;
    set_ri = 1'b0;
    set_ti = 1'b0;
    fire = 1'b0;
    load_ok = 1'b0;
    // baud ticks at sixteen per bit
    m2_lim_hit = m2cnt_r == (cfg_r.double_rate_bit ? `ASP_M2_LIM_DBL : `ASP_M2_LIM_NORM);
    m2cnt_nxt = m2_lim_hit ? 2'h0 : m2cnt_r + 2'h1;
    m2_tick = m2_lim_hit;
    t1_half_nxt = t1_ovf ? ~t1_half_r : t1_half_r;
    t1_tick = t1_ovf && (cfg_r.double_rate_bit || t1_half_r);
    // port 1 has no timer 2 path at all
    rx_tick = (ctrl_r.mode == 2'h2) ? m2_tick
      : ((PORT_ID == 0 && cfg_r.rclk_t2) ? t2_ovf : t1_tick);
    tx_tick = (ctrl_r.mode == 2'h2) ? m2_tick
      : ((PORT_ID == 0 && cfg_r.tclk_t2) ? t2_ovf : t1_tick);
    if (ctrl_r.mode == 2'h0) begin
      rx_tick = 1'b0;
      tx_tick = 1'b0;
    end
    // receiver
    bitv = maj3(smp_r[1], smp_r[0], rx_s_r);
    rvec = {bitv, rsh_r[8:1]};
    lastbit = rvec[8];
    if (rx_tick) begin
      rcnt_nxt = rcnt_r + 4'h1;
      if (rcnt_r == `ASP_SMP_A || rcnt_r == `ASP_SMP_B) begin
        smp_nxt = {smp_r[0], rx_s_r};
      end
    end
    case (rst_r)
      asp_pkg::RX_IDLE: begin
        if (ctrl_r.ren && ctrl_r.mode != 2'h0 && rx_d_r && !rx_s_r) begin
          rst_nxt = asp_pkg::RX_START;
          rcnt_nxt = 4'h0;
        end
      end
      asp_pkg::RX_START: begin
        if (rx_tick && rcnt_r == `ASP_SMP_C) begin
          rst_nxt = bitv ? asp_pkg::RX_IDLE : asp_pkg::RX_DATA;
          ridx_nxt = 4'h0;
        end
      end
      asp_pkg::RX_DATA: begin
        if (rx_tick && rcnt_r == `ASP_SMP_C) begin
          rsh_nxt = rvec;
          ridx_nxt = ridx_r + 4'h1;
          // ninth sample is the stop bit in mode 1, the ninth data bit otherwise
          if (ridx_r == `ASP_LAST_IDX) begin
            fire = 1'b1;
            rst_nxt = asp_pkg::RX_IDLE;
          end
        end
      end
      default: rst_nxt = asp_pkg::RX_IDLE;
    endcase
    if (fire) begin
      load_ok = !ctrl_r.receive_full_flag && (!ctrl_r.address_filter_mode || lastbit);
    end
    // transmitter: divider runs free, frame bits change only at its wrap
    tx_wrap = tx_tick && tcnt_r == `ASP_WRAP;
    if (tx_tick) begin
      tcnt_nxt = tcnt_r + 4'h1;
    end
    if (tx_wrap && trem_r != 4'h0) begin
      txd_nxt = tsh_r[0];
      tsh_nxt = {1'b1, tsh_r[10:1]};
      trem_nxt = trem_r - 4'h1;
      set_ti = trem_r == 4'h1;
    end
    if (tx_wrap && trem_r == 4'h0) begin
      txd_nxt = 1'b1;
    end
    // register access; a write to the buffer outside mode 0 restarts any frame in flight
    if (wr_acc && paddr == `ASP_OFS_CTRL) begin
      ctrl_nxt = pwdata[7:0];
    end
    if (wr_acc && paddr == `ASP_OFS_CFG) begin
      cfg_nxt = {pwdata[`ASP_CFG_DBL], pwdata[`ASP_CFG_RCLK], pwdata[`ASP_CFG_TCLK]};
    end
    if (wr_acc && paddr == `ASP_OFS_BUF && ctrl_r.mode != 2'h0) begin
      if (ctrl_r.mode == 2'h1) begin
        tsh_nxt = {2'b11, pwdata[7:0], 1'b0};
        trem_nxt = `ASP_TX_BITS_M1;
      end else begin
        tsh_nxt = {1'b1, ctrl_r.transmit_ninth_bit, pwdata[7:0], 1'b0};
        trem_nxt = `ASP_TX_BITS_M23;
      end
    end
    // hardware loads win over a software write in the same cycle
    if (load_ok) begin
      rbuf_nxt = rvec[7:0];
      ctrl_nxt.received_ninth_bit = lastbit;
      set_ri = 1'b1;
    end
    if (set_ri) begin
      ctrl_nxt.receive_full_flag = 1'b1;
    end
    if (set_ti) begin
      ctrl_nxt.transmit_done_flag = 1'b1;
    end
    // read data captured in the setup phase, shown in the access phase
    if (rd_setup) begin
      case (paddr)
        `ASP_OFS_CTRL: prdata_nxt = {24'h000000, ctrl_r};
        `ASP_OFS_BUF: prdata_nxt = {24'h000000, rbuf_r};
        `ASP_OFS_CFG: prdata_nxt = {24'h000000, cfg_r.double_rate_bit, 1'b0, cfg_r.rclk_t2,
          cfg_r.tclk_t2, 4'h0};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r <= `ASP_CTRL_RST;
      cfg_r <= 3'h0;
      rst_r <= asp_pkg::RX_IDLE;
      rbuf_r <= 8'h00;
      prdata_r <= 32'h00000000;
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_d_r <= 1'b1;
      m2cnt_r <= 2'h0;
      t1_half_r <= 1'b0;
      rcnt_r <= 4'h0;
      ridx_r <= 4'h0;
      smp_r <= 2'h3;
      rsh_r <= 9'h000;
      tcnt_r <= 4'h0;
      trem_r <= 4'h0;
      tsh_r <= 11'h7ff;
      txd_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      rst_r <= rst_nxt;
      rbuf_r <= rbuf_nxt;
      prdata_r <= prdata_nxt;
      rx_m_r <= rxd;
      rx_s_r <= rx_m_r;
      rx_d_r <= rx_s_r;
      m2cnt_r <= m2cnt_nxt;
      t1_half_r <= t1_half_nxt;
      rcnt_r <= rcnt_nxt;
      ridx_r <= ridx_nxt;
      smp_r <= smp_nxt;
      rsh_r <= rsh_nxt;
      tcnt_r <= tcnt_nxt;
      trem_r <= trem_nxt;
      tsh_r <= tsh_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign prdata = prdata_r;
  assign txd = txd_r;

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a cfg write retunes the divider, so spacing is only judged while the rate holds
  sequence s_m2_slow;
    m2_tick && !cfg_r.double_rate_bit ##1 !cfg_r.double_rate_bit [*4];
  endsequence
  sequence s_m2_fast;
    m2_tick && cfg_r.double_rate_bit ##1 cfg_r.double_rate_bit [*2];
  endsequence

  a_ri_load: assert property (load_ok |=> ctrl_r.receive_full_flag && rbuf_r == $past(rvec[7:0]))
    else $error("receive load did not set flag and buffer");
  a_ri_blocked: assert property (fire && ctrl_r.receive_full_flag |=> $stable(rbuf_r))
    else $error("buffer overwritten while full");
  a_filter_drop: assert property (fire && ctrl_r.address_filter_mode && !lastbit |-> !load_ok)
    else $error("filtered word was loaded");
  a_rb8_copy: assert property (load_ok |=> ctrl_r.received_ninth_bit == $past(lastbit))
    else $error("received ninth bit not copied");
  a_ti_stop: assert property (set_ti |=> txd_r && ctrl_r.transmit_done_flag)
    else $error("done flag not raised at stop bit");
  a_tx_on_wrap: assert property ($fell(txd_r) |-> $past(tx_wrap))
    else $error("transmit edge off the counter wrap");
  a_start_reject: assert property (rst_r == asp_pkg::RX_START && rx_tick && rcnt_r == `ASP_SMP_C && bitv
    |=> rst_r == asp_pkg::RX_IDLE)
    else $error("glitch accepted as start bit");
  a_start_reset: assert property (rst_r == asp_pkg::RX_IDLE && rst_nxt == asp_pkg::RX_START
    |=> rcnt_r == 4'h0 && ctrl_r.ren)
    else $error("divider not reset at start");
  a_mode2_rate: assert property (s_m2_slow |-> m2_tick && !$past(m2_tick) && !$past(m2_tick, 2)
    && !$past(m2_tick, 3))
    else $error("mode 2 tick spacing wrong");
  a_mode2_fast: assert property (s_m2_fast |-> m2_tick && !$past(m2_tick))
    else $error("mode 2 double rate tick spacing wrong");
  a_drop_keeps: assert property (fire && !load_ok && !wr_acc |=> $stable(rbuf_r)
    && $stable(ctrl_r.received_ninth_bit) && $stable(ctrl_r.receive_full_flag))
    else $error("dropped word changed buffer or status");
endmodule : asp_serial_port
`default_nettype wire

// ==== sim/asp_far_end.sv ====
// remote transceiver model: captures frames from the device txd, sends frames on rxd
// assumes the device mclk and a bit time given in mclk cycles; rxd idles high
`default_nettype none
module asp_far_end (
  // clock and line rate
  input wire logic mclk,
  input wire logic [7:0] bit_cycles,
  input wire logic [3:0] nbits,
  // serial lines
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] got = 11'h0;
  int got_cnt = 0;
  initial rxd = 1'h1;
  // ==========================================
  // capture at mid-bit, lsb first
  always begin
    @(negedge txd);
    repeat (bit_cycles / 2) @(posedge mclk);
    for (int i = 0; i < nbits; i++) begin
      got[i] = txd;
      repeat (bit_cycles) @(posedge mclk);
    end
    got_cnt++;
  end
  // ==========================================
  // send: b9 is the ninth bit, or the stop level in ten-bit frames
  task automatic send(input logic [7:0] d, input logic b9, input logic [3:0] nb);
    logic [10:0] f;
    f = {1'h1, b9, d, 1'h0};
    for (int i = 0; i < nb; i++) begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (bit_cycles - 1) @(posedge mclk);
    end
    @(posedge mclk);
    rxd <= 1'h1;
  endtask : send
  // short low pulse, too brief to pass start qualification
  task automatic pulse(input int n);
    @(posedge mclk);
    rxd <= 1'h0;
    repeat (n) @(posedge mclk);
    rxd <= 1'h1;
  endtask : pulse
endmodule : asp_far_end
`default_nettype wire

// ==== sim/asp_serial_port_tb.sv ====
// self-checking bench: apb register access, frames in both directions, filter and drops
// assumes asp_far_end on the serial lines; timer overflow pulses are made here
`default_nettype none
module asp_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, psel, penable, pwrite, t1_ovf, t2_ovf, pready, pslverr, txd, rxd, b9, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] bitp, d;
  logic [3:0] nb;
  logic [1:0] m;
  int failures = 0;
  int cmp_count = 0;
  int ovf_cnt = 0;
  int n0;
  // t1 every 2nd cycle, t2 every 3rd: bit times 64/32 for t1, 48 for t2
  localparam logic [1:0] mode_tab [6] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h1};
  localparam logic [31:0] cfg_tab [6] = '{32'h0, 32'h80, 32'h0, 32'h80, 32'hb0, 32'h30};
  localparam logic [7:0] bit_tab [6] = '{8'h40, 8'h20, 8'h40, 8'h20, 8'h30, 8'h30};
  asp_serial_port #(.PORT_ID(0)) uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .t1_ovf(t1_ovf), .t2_ovf(t2_ovf), .rxd(rxd), .txd(txd));
  asp_far_end far (.mclk(mclk), .bit_cycles(bitp), .nbits(nb), .txd(txd), .rxd(rxd));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ovf_cnt <= ovf_cnt + 1;
    t1_ovf <= (ovf_cnt % 2 == 0);
    t2_ovf <= (ovf_cnt % 3 == 0);
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  function automatic logic [31:0] ctl(input logic [1:0] mm, input logic f, input logic r, input logic t);
    return {24'h0, mm, f, r, t, 3'h0};
  endfunction : ctl
  function automatic logic [31:0] frame(input logic [7:0] v, input logic n9, input logic [3:0] n);
    return (n == 4'hb) ? {21'h0, 1'h1, n9, v, 1'h0} : {22'h0, 1'h1, v, 1'h0};
  endfunction : frame
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
  // ==========================================
  // main sequence
  initial begin
    rstn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bitp = 8'h40;
    nb = 4'ha;
    void'($urandom(98));
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    chk({31'h0, txd}, 32'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(1'h0, 12'h00c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // a buffer write in mode 0 must not leave a frame pending for a later mode
    apb(1'h1, 12'h004, $urandom);
    apb(1'h1, 12'h000, ctl(2'h1, 1'h0, 1'h0, 1'h0));
    repeat (800) @(posedge mclk);
    chk(32'(far.got_cnt), 32'h0);
    for (int k = 0; k < 6; k++) begin
      m = mode_tab[k];
      bitp = bit_tab[k];
      nb = (m == 2'h1) ? 4'ha : 4'hb;
      apb(1'h1, 12'h008, cfg_tab[k]);
      apb(1'h0, 12'h008, 32'h0);
      chk(rd, cfg_tab[k]);
      d = 8'($urandom);
      b9 = 1'($urandom);
      apb(1'h1, 12'h000, ctl(m, 1'h0, 1'h1, b9));
      n0 = far.got_cnt;
      apb(1'h1, 12'h004, {24'h0, d});
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h2, 32'h0);
      for (int i = 0; i < 2000 && far.got_cnt == n0; i++) @(posedge mclk);
      chk(32'(far.got_cnt - n0), 32'h1);
      chk(32'(far.got) & ((nb == 4'hb) ? 32'h7ff : 32'h3ff), frame(d, b9, nb));
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h2, 32'h2);
      apb(1'h1, 12'h000, ctl(m, 1'h0, 1'h1, 1'h0));
      d = 8'($urandom);
      b9 = 1'($urandom);
      far.send(d, b9, nb);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h5, {29'h0, b9, 2'h1});
      apb(1'h0, 12'h004, 32'h0);
      chk(rd, {24'h0, d});
      far.send(~d, ~b9, nb);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd, {24'h0, d});
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h5, {29'h0, b9, 2'h1});
      apb(1'h1, 12'h000, ctl(m, 1'h1, 1'h1, 1'h0));
      far.send(~d, 1'h1, nb);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h5, 32'h5);
      apb(1'h1, 12'h000, ctl(m, 1'h1, 1'h1, 1'h0) | 32'h4);
      far.send(d, 1'h0, nb);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h5, 32'h4);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd, {24'h0, ~d});
      apb(1'h1, 12'h000, ctl(m, 1'h0, 1'h0, 1'h0));
      far.send(d, 1'h1, nb);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h1, 32'h0);
      apb(1'h1, 12'h000, ctl(m, 1'h0, 1'h1, 1'h0));
      far.pulse(bitp / 4);
      repeat (int'(nb) * int'(bitp)) @(posedge mclk);
      apb(1'h0, 12'h000, 32'h0);
      chk(rd & 32'h1, 32'h0);
      $display("config %0d done", k);
    end
    report_and_stop();
  end
endmodule : asp_serial_port_tb
`default_nettype wire
